// ===== pkg/pmb_pkg.sv
// Package with register map, field positions and pad types for the pin 9 pad block.
package pmb_pkg;
    localparam logic [7:0] PMB_OFF_SCRATCH_FIRST = 8'h18;
    localparam logic [7:0] PMB_OFF_SCRATCH_SECOND = 8'h19;
    localparam logic [7:0] PMB_OFF_PAD_CONFIG = 8'h1A;
    localparam logic [7:0] PMB_RST_SCRATCH_FIRST = 8'h00;
    localparam logic [7:0] PMB_RST_SCRATCH_SECOND = 8'h01;
    localparam logic [7:0] PMB_RST_PAD_CONFIG = 8'h00;
    localparam int PMB_BIT_GLOBAL_LEVEL = 7;
    localparam int PMB_BIT_GLOBAL_DIR = 5;
    localparam int PMB_BIT_GLOBAL_EN = 4;
    localparam int PMB_BIT_PIN9_LEVEL = 3;
    localparam int PMB_BIT_PIN9_DIR = 1;
    localparam int PMB_BIT_PIN9_EN = 0;
    localparam int PMB_NUM_PINS = 4;

    // Two-bit pad code, {direction, enable}.
    typedef enum logic [1:0] {
        PMB_PAD_FUNC_OUT = 2'h0,
        PMB_PAD_FORCE_OUT = 2'h1,
        PMB_PAD_HIGH_Z = 2'h2,
        PMB_PAD_FORCE_IN = 2'h3
    } pmb_pad_code_t;

    // Register access request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pmb_req_t;

    // Drive of one pad: output value and active-low output enable.
    typedef struct packed {
        logic level;
        logic oe_n;
    } pmb_pad_t;
endpackage

// ===== hw/pmb_pad_mux.sv
// Pad mux that resolves one pin's drive from its own and the global settings.
`timescale 1ns/10ps
module pmb_pad_mux
    import pmb_pkg::*;
(
    // Local setting of this pin
    input wire logic local_valid,
    input wire pmb_pad_code_t local_code,
    input wire logic local_level,
    input wire logic remote_enable,
    input wire logic remote_level,
    // Global fallback
    input wire pmb_pad_code_t global_code,
    input wire logic global_level,
    // Functional path of the pin
    input wire logic func_level,
    // Resolved pad drive
    output pmb_pad_t pad
);
    wire logic local_gpio;
    wire pmb_pad_code_t eff_code;
    wire logic eff_level;

    // A pin with its own enable set overrides the global force bits.
    assign local_gpio = local_valid && local_code[0];
    assign eff_code = local_gpio ? local_code : global_code;
    // The local level drives only for output direction with remote control off.
    assign eff_level = local_gpio ? (remote_enable ? remote_level : local_level)
                                  : global_level;

    always_comb begin
        pad = '{level: 1'b0, oe_n: 1'b1};
        case (eff_code)
            PMB_PAD_FUNC_OUT: begin
                pad = '{level: func_level, oe_n: 1'b0};
            end
            PMB_PAD_FORCE_OUT: begin
                pad = '{level: eff_level, oe_n: 1'b0};
            end
            default: begin
                pad = '{level: 1'b0, oe_n: 1'b1};
            end
        endcase
    end
endmodule

// ===== hw/pmb_top.sv
// Scratch message registers and pin 9 / global fallback pad configuration.
//
// How it works
// - Two 8-bit scratch registers read and write freely with no side effects.
// - The scratch register at 18h resets to zero and the one at 19h resets to one.
// - The global pad code is {direction-force bit 5, enable-force bit 4}.
// - Global code 00 is functional output, 10 high impedance, 01 forced out, 11 forced in.
// - A pin's own direction and enable override the global force bits.
// - A pin not locally enabled under global forced-out mode drives the global level in bit 7.
// - Pin 9 code is {direction bit 1, enable bit 0}; 01 forced out, 11 forced in, 00 and 10 use the global code.
// - Pin 9 drives bit 3 only when enabled, set to output and remote control off.
// - The pad configuration register at 1Ah resets to zero.
`timescale 1ns/10ps
module pmb_top
    import pmb_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register access from the control interface
    input wire pmb_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    // Per-pin state of the other pad registers
    input wire logic [PMB_NUM_PINS-1:0] pin_local_valid,
    input wire logic [2*PMB_NUM_PINS-1:0] pin_local_code,
    input wire logic [PMB_NUM_PINS-1:0] pin_local_level,
    input wire logic [PMB_NUM_PINS-1:0] pin_remote_enable,
    input wire logic [PMB_NUM_PINS-1:0] pin_remote_level,
    input wire logic [PMB_NUM_PINS-1:0] pin_func_level,
    // Pin 9 link-side inputs
    input wire logic pin9_remote_enable,
    input wire logic pin9_remote_level,
    input wire logic pin9_func_level,
    input wire logic pin9_in,
    // Pad drives
    output logic pin9_out,
    output logic pin9_oe_n,
    output logic pin9_sampled,
    output logic [PMB_NUM_PINS-1:0] pin_out,
    output logic [PMB_NUM_PINS-1:0] pin_oe_n
);
    logic [7:0] scratch_message_first;
    logic [7:0] scratch_message_second;
    logic [7:0] pin9_and_fallback_pad_config;

    wire logic hit_first;
    wire logic hit_second;
    wire logic hit_pad;
    wire logic [7:0] next_rdata;
    wire pmb_pad_code_t global_code;
    wire logic global_level;
    wire pmb_pad_code_t pin9_code;
    wire logic pin9_enable;
    wire logic pin9_direction;
    wire logic pin9_drive_level;
    wire pmb_pad_t pin9_pad;
    wire pmb_pad_t pin_pad [PMB_NUM_PINS];

    assign hit_first = (req.addr == PMB_OFF_SCRATCH_FIRST);
    assign hit_second = (req.addr == PMB_OFF_SCRATCH_SECOND);
    assign hit_pad = (req.addr == PMB_OFF_PAD_CONFIG);

    // Unmapped addresses read as zero so software sees a defined value.
    assign next_rdata = hit_first ? scratch_message_first :
                        hit_second ? scratch_message_second :
                        hit_pad ? pin9_and_fallback_pad_config : 8'h00;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            scratch_message_first <= PMB_RST_SCRATCH_FIRST;
            scratch_message_second <= PMB_RST_SCRATCH_SECOND;
            pin9_and_fallback_pad_config <= PMB_RST_PAD_CONFIG;
        end else if (req.wr) begin
            if (hit_first) begin
                scratch_message_first <= req.wdata;
            end
            if (hit_second) begin
                scratch_message_second <= req.wdata;
            end
            if (hit_pad) begin
                pin9_and_fallback_pad_config <= req.wdata;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rdata <= req.rd ? next_rdata : rdata;
            rvalid <= req.rd;
        end
    end

    assign global_code = pmb_pad_code_t'({pin9_and_fallback_pad_config[PMB_BIT_GLOBAL_DIR],
                                          pin9_and_fallback_pad_config[PMB_BIT_GLOBAL_EN]});
    assign global_level = pin9_and_fallback_pad_config[PMB_BIT_GLOBAL_LEVEL];
    assign pin9_direction = pin9_and_fallback_pad_config[PMB_BIT_PIN9_DIR];
    assign pin9_enable = pin9_and_fallback_pad_config[PMB_BIT_PIN9_EN];
    assign pin9_drive_level = pin9_and_fallback_pad_config[PMB_BIT_PIN9_LEVEL];
    assign pin9_code = pmb_pad_code_t'({pin9_direction, pin9_enable});

    // Pin 9 always has its own setting, so the global code applies only when it is disabled.
    pmb_pad_mux u_pin9 (
        .local_valid(1'b1),
        .local_code(pin9_code),
        .local_level(pin9_drive_level),
        .remote_enable(pin9_remote_enable),
        .remote_level(pin9_remote_level),
        .global_code(global_code),
        .global_level(global_level),
        .func_level(pin9_func_level),
        .pad(pin9_pad)
    );

    genvar gi;
    generate
        for (gi = 0; gi < PMB_NUM_PINS; gi++) begin : g_pin
            pmb_pad_mux u_mux (
                .local_valid(pin_local_valid[gi]),
                .local_code(pmb_pad_code_t'(pin_local_code[2*gi +: 2])),
                .local_level(pin_local_level[gi]),
                .remote_enable(pin_remote_enable[gi]),
                .remote_level(pin_remote_level[gi]),
                .global_code(global_code),
                .global_level(global_level),
                .func_level(pin_func_level[gi]),
                .pad(pin_pad[gi])
            );
        end
    endgenerate

    // Registered pad outputs add one cycle of latency after a register write.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pin9_out <= 1'b0;
            pin9_oe_n <= 1'b0;
            pin9_sampled <= 1'b0;
            pin_out <= '0;
            pin_oe_n <= '0;
        end else begin
            pin9_out <= pin9_pad.level;
            pin9_oe_n <= pin9_pad.oe_n;
            pin9_sampled <= pin9_in;
            for (int i = 0; i < PMB_NUM_PINS; i++) begin
                pin_out[i] <= pin_pad[i].level;
                pin_oe_n[i] <= pin_pad[i].oe_n;
            end
        end
    end

    // A pad write is taken at one edge and reaches the pad flops at the next edge.
    sequence s_pad_write(logic [7:0] v);
        req.wr && hit_pad && req.wdata == v;
    endsequence

    sequence s_pin9_gpio_out;
        pin9_code == PMB_PAD_FORCE_OUT;
    endsequence

    // Pin 9 falls back to the global code whenever its own enable bit is clear.
    sequence s_pin9_on_global;
        !pin9_enable;
    endsequence

    // Pin 0 stands in for every other pin that follows the global fallback.
    sequence s_pin0_on_global;
        !pin_local_valid[0];
    endsequence

    // Register bus checks.
    scratch_keeps_a: assert property (@(posedge mclk) disable iff (reset)
        req.wr && hit_first |=> scratch_message_first == $past(req.wdata))
        else $error("first scratch did not store write");

    scratch_second_a: assert property (@(posedge mclk) disable iff (reset)
        req.wr && hit_second |=> scratch_message_second == $past(req.wdata))
        else $error("second scratch did not store write");

    // Reads must have no side effect on the scratch contents.
    scratch_hold_a: assert property (@(posedge mclk) disable iff (reset)
        !req.wr |=> $stable(scratch_message_first) && $stable(scratch_message_second))
        else $error("scratch changed without a write");

    read_first_a: assert property (@(posedge mclk) disable iff (reset)
        req.rd && hit_first |=> rdata == $past(scratch_message_first))
        else $error("first scratch read back wrong");

    read_second_a: assert property (@(posedge mclk) disable iff (reset)
        req.rd && hit_second |=> rdata == $past(scratch_message_second))
        else $error("second scratch read back wrong");

    read_pad_a: assert property (@(posedge mclk) disable iff (reset)
        req.rd && hit_pad |=> rdata == $past(pin9_and_fallback_pad_config))
        else $error("pad config read back wrong");

    read_unmapped_a: assert property (@(posedge mclk) disable iff (reset)
        req.rd && !hit_first && !hit_second && !hit_pad |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    read_valid_a: assert property (@(posedge mclk) disable iff (reset)
        1'b1 |=> rvalid == $past(req.rd))
        else $error("read valid does not follow the read strobe");

    scratch_reset_a: assert property (@(posedge mclk)
        reset |=> (scratch_message_second == 8'h01 && scratch_message_first == 8'h00))
        else $error("scratch reset values wrong");

    pad_reset_a: assert property (@(posedge mclk)
        reset |=> pin9_and_fallback_pad_config == 8'h00)
        else $error("pad config reset value wrong");

    pad_hold_a: assert property (@(posedge mclk) disable iff (reset)
        !(req.wr && hit_pad) |=> $stable(pin9_and_fallback_pad_config))
        else $error("pad config changed without a write");

    reserved_store_a: assert property (@(posedge mclk) disable iff (reset)
        s_pad_write(8'h44) |=> pin9_and_fallback_pad_config[6] && pin9_and_fallback_pad_config[2])
        else $error("reserved bits not stored");

    global_code_a: assert property (@(posedge mclk) disable iff (reset)
        global_code == {pin9_and_fallback_pad_config[5], pin9_and_fallback_pad_config[4]})
        else $error("global code bit order wrong");

    // Pin 9 checks, written on the written value and on the decoded code.
    pin9_gpio_out_a: assert property (@(posedge mclk) disable iff (reset)
        s_pad_write(8'h09) && !pin9_remote_enable ##1 !pin9_remote_enable
        |=> (pin9_out == 1'b1 && pin9_oe_n == 1'b0))
        else $error("pin 9 does not drive its local level");

    pin9_local_level_a: assert property (@(posedge mclk) disable iff (reset)
        s_pin9_gpio_out ##0 !pin9_remote_enable
        |=> pin9_out == $past(pin9_drive_level) && !pin9_oe_n)
        else $error("pin 9 local level not driven");

    pin9_remote_a: assert property (@(posedge mclk) disable iff (reset)
        s_pin9_gpio_out ##0 pin9_remote_enable
        |=> pin9_out == $past(pin9_remote_level) && !pin9_oe_n)
        else $error("pin 9 remote level not driven");

    pin9_tristate_a: assert property (@(posedge mclk) disable iff (reset)
        s_pad_write(8'hFA) |=> ##1 pin9_oe_n)
        else $error("pin 9 not tri-stated");

    pin9_input_a: assert property (@(posedge mclk) disable iff (reset)
        s_pad_write(8'h03) |=> ##1 pin9_oe_n)
        else $error("pin 9 not an input");

    pin9_force_in_a: assert property (@(posedge mclk) disable iff (reset)
        pin9_code == PMB_PAD_FORCE_IN |=> pin9_oe_n)
        else $error("pin 9 input code still drives");

    global_fallback_a: assert property (@(posedge mclk) disable iff (reset)
        s_pad_write(8'h90) |=> ##1 (pin9_out == 1'b1 && !pin9_oe_n))
        else $error("global level not driven on disabled pin");

    pin9_global_a: assert property (@(posedge mclk) disable iff (reset)
        s_pin9_on_global ##0 global_code == PMB_PAD_FORCE_OUT
        |=> pin9_out == $past(global_level) && !pin9_oe_n)
        else $error("pin 9 does not follow the global level");

    pin9_func_a: assert property (@(posedge mclk) disable iff (reset)
        s_pin9_on_global ##0 global_code == PMB_PAD_FUNC_OUT
        |=> pin9_out == $past(pin9_func_level) && !pin9_oe_n)
        else $error("pin 9 functional output wrong");

    pin9_global_off_a: assert property (@(posedge mclk) disable iff (reset)
        s_pin9_on_global ##0 global_code[1] |=> pin9_oe_n)
        else $error("pin 9 drives under a global off code");

    global_hiz_a: assert property (@(posedge mclk) disable iff (reset)
        s_pad_write(8'h20) |=> ##1 pin9_oe_n)
        else $error("global high impedance not applied");

    local_override_a: assert property (@(posedge mclk) disable iff (reset)
        s_pad_write(8'hA1) && !pin9_remote_enable ##1 !pin9_remote_enable
        |=> (!pin9_oe_n && pin9_out == 1'b0))
        else $error("local setting did not override global");

    pin9_sample_a: assert property (@(posedge mclk) disable iff (reset)
        1'b1 |=> pin9_sampled == $past(pin9_in))
        else $error("pin 9 input not sampled");

    // Fallback pin checks.
    pin0_global_a: assert property (@(posedge mclk) disable iff (reset)
        s_pin0_on_global ##0 global_code == PMB_PAD_FORCE_OUT
        |=> pin_out[0] == $past(global_level) && !pin_oe_n[0])
        else $error("fallback pin does not follow the global level");

    pin0_func_a: assert property (@(posedge mclk) disable iff (reset)
        s_pin0_on_global ##0 global_code == PMB_PAD_FUNC_OUT
        |=> pin_out[0] == $past(pin_func_level[0]) && !pin_oe_n[0])
        else $error("fallback pin functional output wrong");

    pin0_off_a: assert property (@(posedge mclk) disable iff (reset)
        s_pin0_on_global ##0 global_code[1] |=> pin_oe_n[0])
        else $error("fallback pin drives under a global off code");

    // The local direction decides alone once the pin's own enable is set.
    pin0_local_a: assert property (@(posedge mclk) disable iff (reset)
        pin_local_valid[0] && pin_local_code[0] |=> pin_oe_n[0] == $past(pin_local_code[1]))
        else $error("local setting of pin 0 did not win");

    pin0_remote_a: assert property (@(posedge mclk) disable iff (reset)
        pin_local_valid[0] && pin_local_code[1:0] == 2'b01 && pin_remote_enable[0]
        |=> pin_out[0] == $past(pin_remote_level[0]))
        else $error("pin 0 remote level not driven");
endmodule

// ===== bench/pmb_tb.sv
// Self-checking bench for the scratch registers and the pin 9 / fallback pad control.
`timescale 1ns/10ps
module tb
    import pmb_pkg::*;
;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    pmb_req_t req = '0;
    logic [7:0] rdata;
    logic rvalid;
    logic [3:0] pin_local_valid = 4'h0;
    logic [7:0] pin_local_code = 8'h00;
    logic [3:0] pin_local_level = 4'h5;
    logic [3:0] pin_remote_enable = 4'h0;
    logic [3:0] pin_remote_level = 4'h0;
    logic [3:0] pin_func_level = 4'hA;
    logic pin9_remote_enable = 1'b0;
    logic pin9_remote_level = 1'b0;
    logic pin9_func_level = 1'b1;
    logic pin9_in = 1'b0;
    logic pin9_out;
    logic pin9_oe_n;
    logic pin9_sampled;
    logic [3:0] pin_out;
    logic [3:0] pin_oe_n;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [1:0] gc;
    logic lv;

    pmb_top dut (.mclk(mclk), .reset(reset), .req(req), .rdata(rdata), .rvalid(rvalid),
        .pin_local_valid(pin_local_valid), .pin_local_code(pin_local_code),
        .pin_local_level(pin_local_level), .pin_remote_enable(pin_remote_enable),
        .pin_remote_level(pin_remote_level), .pin_func_level(pin_func_level),
        .pin9_remote_enable(pin9_remote_enable), .pin9_remote_level(pin9_remote_level),
        .pin9_func_level(pin9_func_level), .pin9_in(pin9_in), .pin9_out(pin9_out),
        .pin9_oe_n(pin9_oe_n), .pin9_sampled(pin9_sampled), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n));

    always #10 mclk = ~mclk;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // The whole run needs about 120 cycles, so a hang is cut off at 2000, far beyond that.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // The strobe stands for exactly one cycle and is taken at the edge that clears it.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk) req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk) req.rd <= 1'b0;
        #1;
        chk({7'h0, rvalid}, 8'h01);
        chk(rdata, e);
    endtask

    // Pads follow a write after the register edge and one output flop.
    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic pad9(input logic o, input logic oe);
        chk({6'h0, pin9_out, pin9_oe_n}, {6'h0, o, oe});
    endtask

    initial begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        rd(8'h18, 8'h00);
        rd(8'h19, 8'h01);
        rd(8'h1A, 8'h00);
        pad9(1'b1, 1'b0);
        wr(8'h18, 8'hA5);
        wr(8'h19, 8'h5A);
        wr(8'h1B, 8'hFF);
        rd(8'h18, 8'hA5);
        rd(8'h19, 8'h5A);
        rd(8'h1B, 8'h00);
        wr(8'h1A, 8'h44);
        rd(8'h1A, 8'h44);
        settle();
        pad9(1'b1, 1'b0);
        chk({pin_out, pin_oe_n}, 8'hA0);
        for (int g = 0; g < 8; g++) begin
            gc = g[1:0];
            lv = g[2];
            wr(8'h1A, {lv, 1'b0, gc, 4'h0});
            settle();
            chk({4'h0, pin_oe_n}, {4'h0, {4{gc[1]}}});
            if (gc == 2'b00) chk({4'h0, pin_out}, 8'h0A);
            if (gc == 2'b01) chk({4'h0, pin_out}, {4'h0, {4{lv}}});
            chk({7'h0, pin9_oe_n}, {7'h0, gc[1]});
        end
        for (int c = 0; c < 8; c++) begin
            gc = c[1:0];
            lv = c[2];
            wr(8'h1A, {4'h0, lv, 1'b0, gc});
            settle();
            if (gc == 2'b01) pad9(lv, 1'b0);
            else if (gc == 2'b11) chk({7'h0, pin9_oe_n}, 8'h01);
            else pad9(1'b1, 1'b0);
        end
        @(posedge mclk) pin9_remote_enable <= 1'b1;
        wr(8'h1A, 8'h09);
        settle();
        pad9(1'b0, 1'b0);
        @(posedge mclk) pin9_remote_enable <= 1'b0;
        settle();
        pad9(1'b1, 1'b0);
        wr(8'h1A, 8'hA1);
        settle();
        pad9(1'b0, 1'b0);
        chk({4'h0, pin_oe_n}, 8'h0F);
        wr(8'h1A, 8'hFA);
        settle();
        pad9(1'b0, 1'b1);
        @(posedge mclk) pin_local_valid <= 4'h1;
        pin_local_code <= 8'h01;
        wr(8'h1A, 8'h39);
        settle();
        pad9(1'b1, 1'b0);
        chk({4'h0, pin_oe_n}, 8'h0E);
        chk({7'h0, pin_out[0]}, 8'h01);
        @(posedge mclk) pin9_in <= 1'b1;
        settle();
        chk({7'h0, pin9_sampled}, 8'h01);
        end_sim();
    end
endmodule
